// >>> verilog/flash_pe_regs.svh
// Register indices, field positions, key codes and reset values of the flash control block.
`ifndef FLASH_PE_REGS_SVH
`define FLASH_PE_REGS_SVH

`define IDX_WE_PROTECT    30'h0008_c289
`define IDX_ACC_STATUS    30'h007f_c410
`define IDX_ACC_IRQ_EN    30'h007f_c411
`define IDX_SEQ_RAM_EN    30'h007f_c454
`define IDX_STATUS_0      30'h007f_ffb0
`define IDX_STATUS_1      30'h007f_ffb1
`define IDX_PE_ENTRY      30'h007f_ffb2
`define IDX_LOCK_PROTECT  30'h007f_ffb4
`define IDX_SEQ_RESET     30'h007f_ffb6
`define IDX_PCLK_NOTIFY   30'h007f_ffe8

`define BIT_DF_WP         0
`define BIT_DF_RP         1
`define BIT_DF_ACC        3
`define BIT_CMD_LOCK      4
`define BIT_CF_ACC        7
`define BIT_PRG_ERR       4
`define BIT_ERS_ERR       5
`define BIT_ILGL_ERR      6
`define BIT_READY         7
`define BIT_SEQ_ERR       7
`define BIT_CF_ENTRY      0
`define BIT_DF_ENTRY      7

`define FLAG_MASK         8'h8b
`define IRQ_EN_MASK       8'h9b
`define KEY_RAM_EN        8'hc4
`define KEY_LOCK          8'h55
`define KEY_RESET         8'hcc
`define KEY_ENTRY         8'haa
`define STRB_HALF         4'h3
`define WE_PERMIT_ON      2'h1
`define WE_PERMIT_OFF     2'h2

`define RST_RAM_EN        1'b0
`define RST_LOCK_CANCEL   1'b0
`define RST_SEQ_RESET     1'b0
`define RST_PCLK_MHZ      8'h00
`define RST_WE_PERMIT     2'h1
`define RST_CMD_LOCK      1'b1

`endif

// >>> verilog/flash_pe_pkg.sv
// Types shared by the flash control block.
package flash_pe_pkg;

   typedef struct packed {
      logic [7:0]  acc_flags;
      logic [7:0]  armed;
      logic [7:0]  irq_en;
      logic        ram_en;
      logic        lock_cancel;
      logic        seq_reset;
      logic        cf_entry;
      logic        df_entry;
      logic [7:0]  pclk_mhz;
      logic [1:0]  we_permit;
      logic [7:0]  stat0;
      logic [7:0]  stat1;
      logic        cmd_locked;
      logic        irq;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } ctl_state_t;

endpackage

// >>> verilog/flash_pe_control_registers.sv
// APB register file and status logic of the flash program/erase sequencer.
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "flash_pe_regs.svh"

module flash_pe_control_registers (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rstn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // Access events from the flash interface.
   input  wire logic        dflash_pe_cmd,
   input  wire logic        dflash_read,
   input  wire logic        dflash_write_enable_setting,
   input  wire logic        dflash_read_enable_setting,
   input  wire logic        dflash_illegal_access,
   input  wire logic        code_flash_illegal_access,
   // Sequencer status.
   input  wire logic        seq_command_locked,
   input  wire logic        seq_program_error,
   input  wire logic        seq_erase_error,
   input  wire logic        seq_illegal_command,
   input  wire logic        seq_pe_busy,
   input  wire logic        seq_cancel_busy,
   input  wire logic        seq_lock_read_busy,
   input  wire logic        seq_blank_check_busy,
   input  wire logic        seq_processing_error,
   // Control outputs.
   output var  logic        flash_access_error_irq,
   output var  logic        sequencer_ram_access_en,
   output var  logic        lock_protection_cancel,
   output var  logic        sequencer_reset_bit,
   output var  logic        code_flash_pe_entry,
   output var  logic        data_flash_pe_entry,
   output var  logic [7:0]  periph_clock_mhz,
   output var  logic        write_erase_allowed
);
   import flash_pe_pkg::*;

   ctl_state_t s_r;
   ctl_state_t s_nxt;
   logic       we_ok_r;
   logic       we_ok_nxt;

   // True when the word address selects the register of the given index.
   function automatic logic hit(input logic [31:0] a, input logic [29:0] idx);
      hit = (a[31:2] == idx);
   endfunction

   // True for a 16-bit low-half write whose upper byte carries the key.
   function automatic logic key_ok(input logic [3:0] st, input logic [31:0] d,
                                   input logic [7:0] key);
      key_ok = (st == `STRB_HALF) && (d[15:8] == key);
   endfunction

   function automatic logic mapped(input logic [31:0] a);
      mapped = hit(a, `IDX_WE_PROTECT) || hit(a, `IDX_ACC_STATUS) ||
               hit(a, `IDX_ACC_IRQ_EN) || hit(a, `IDX_SEQ_RAM_EN) ||
               hit(a, `IDX_STATUS_0) || hit(a, `IDX_STATUS_1) ||
               hit(a, `IDX_PE_ENTRY) || hit(a, `IDX_LOCK_PROTECT) ||
               hit(a, `IDX_SEQ_RESET) || hit(a, `IDX_PCLK_NOTIFY);
   endfunction

   logic       access_wait;
   logic       commit;
   logic       wr;
   logic       rd;
   logic [7:0] set_v;
   logic [7:0] clr_v;
   logic [7:0] acc_view;
   logic [7:0] flags_n;
   logic [31:0] rdata;

   always_comb begin
      s_nxt       = s_r;
      access_wait = psel && penable && !s_r.pready;
      commit      = psel && penable && s_r.pready;
      wr          = commit && pwrite;
      rd          = commit && !pwrite;

      // Pick up the sequencer's own status every cycle.
      s_nxt.cmd_locked = seq_command_locked;
      s_nxt.stat0 = 8'h00;
      s_nxt.stat0[`BIT_PRG_ERR]  = seq_program_error;
      s_nxt.stat0[`BIT_ERS_ERR]  = seq_erase_error;
      s_nxt.stat0[`BIT_ILGL_ERR] = seq_illegal_command;
      s_nxt.stat0[`BIT_READY]    = !(seq_pe_busy || seq_cancel_busy ||
                                     seq_lock_read_busy || seq_blank_check_busy);
      s_nxt.stat1 = 8'h00;
      s_nxt.stat1[`BIT_SEQ_ERR]  = seq_processing_error;

      // Violation events.
      set_v = 8'h00;
      set_v[`BIT_DF_WP]  = dflash_pe_cmd && !dflash_write_enable_setting;
      set_v[`BIT_DF_RP]  = dflash_read && !dflash_read_enable_setting;
      set_v[`BIT_DF_ACC] = dflash_illegal_access;
      set_v[`BIT_CF_ACC] = code_flash_illegal_access;

      // A zero written over a flag clears it only if that flag was read as one.
      clr_v = 8'h00;
      if (wr && hit(paddr, `IDX_ACC_STATUS) && pstrb[0]) begin
         clr_v = s_r.armed & ~pwdata[7:0] & `FLAG_MASK;
      end
      // Flags hold until cleared; sequencer reset also clears; a new event wins.
      if (s_r.seq_reset) begin
         flags_n = set_v;
      end else begin
         flags_n = (s_r.acc_flags & ~clr_v) | set_v;
      end
      s_nxt.acc_flags = flags_n & `FLAG_MASK;

      // A read arms the flags seen as one; a flag that drops disarms itself.
      if (rd && hit(paddr, `IDX_ACC_STATUS)) begin
         s_nxt.armed = s_r.acc_flags & `FLAG_MASK;
      end else begin
         s_nxt.armed = s_r.armed & flags_n;
      end

      // Plain read/write registers.
      if (wr && pstrb[0]) begin
         if (hit(paddr, `IDX_ACC_IRQ_EN)) begin
            s_nxt.irq_en = pwdata[7:0] & `IRQ_EN_MASK;
         end
         if (hit(paddr, `IDX_PCLK_NOTIFY)) begin
            s_nxt.pclk_mhz = pwdata[7:0];
         end
         if (hit(paddr, `IDX_WE_PROTECT)) begin
            s_nxt.we_permit = pwdata[1:0];
         end
      end

      // Key-guarded registers; the key byte itself is never kept.
      if (wr && hit(paddr, `IDX_SEQ_RAM_EN) &&
          key_ok(pstrb, pwdata, `KEY_RAM_EN)) begin
         s_nxt.ram_en = pwdata[0];
      end
      if (wr && hit(paddr, `IDX_LOCK_PROTECT) &&
          key_ok(pstrb, pwdata, `KEY_LOCK) &&
          (s_r.cf_entry || s_r.df_entry)) begin
         s_nxt.lock_cancel = pwdata[0];
      end
      if (wr && hit(paddr, `IDX_SEQ_RESET) &&
          key_ok(pstrb, pwdata, `KEY_RESET)) begin
         s_nxt.seq_reset = pwdata[0];
      end
      if (wr && hit(paddr, `IDX_PE_ENTRY) &&
          key_ok(pstrb, pwdata, `KEY_ENTRY)) begin
         s_nxt.cf_entry = pwdata[`BIT_CF_ENTRY];
         s_nxt.df_entry = pwdata[`BIT_DF_ENTRY];
      end

      // Interrupt follows any enabled flag, command lock included.
      acc_view = s_nxt.acc_flags;
      acc_view[`BIT_CMD_LOCK] = s_nxt.cmd_locked;
      s_nxt.irq = |(acc_view & s_nxt.irq_en & `IRQ_EN_MASK);

      // Read mux; upper key bytes read as zero.
      rdata = 32'h0000_0000;
      case (1'b1)
         hit(paddr, `IDX_WE_PROTECT):   rdata[1:0] = s_r.we_permit;
         hit(paddr, `IDX_ACC_STATUS): begin
            rdata[7:0] = s_r.acc_flags;
            rdata[`BIT_CMD_LOCK] = s_r.cmd_locked;
         end
         hit(paddr, `IDX_ACC_IRQ_EN):   rdata[7:0] = s_r.irq_en;
         hit(paddr, `IDX_SEQ_RAM_EN):   rdata[0] = s_r.ram_en;
         hit(paddr, `IDX_STATUS_0):     rdata[7:0] = s_r.stat0;
         hit(paddr, `IDX_STATUS_1):     rdata[7:0] = s_r.stat1;
         hit(paddr, `IDX_PE_ENTRY): begin
            rdata[`BIT_CF_ENTRY] = s_r.cf_entry;
            rdata[`BIT_DF_ENTRY] = s_r.df_entry;
         end
         hit(paddr, `IDX_LOCK_PROTECT): rdata[0] = s_r.lock_cancel;
         hit(paddr, `IDX_SEQ_RESET):    rdata[0] = s_r.seq_reset;
         hit(paddr, `IDX_PCLK_NOTIFY):  rdata[7:0] = s_r.pclk_mhz;
         default:                       rdata = 32'h0000_0000;
      endcase

      // One wait state: answer data and error are registered at the same edge as pready.
      s_nxt.pready = access_wait;
      if (access_wait) begin
         s_nxt.prdata  = pwrite ? 32'h0000_0000 : rdata;
         s_nxt.pslverr = !mapped(paddr);
      end else if (commit) begin
         s_nxt.prdata  = 32'h0000_0000;
         s_nxt.pslverr = 1'b0;
      end

      we_ok_nxt = (s_nxt.we_permit == `WE_PERMIT_ON);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_r             <= '0;
         s_r.ram_en      <= `RST_RAM_EN;
         s_r.lock_cancel <= `RST_LOCK_CANCEL;
         s_r.seq_reset   <= `RST_SEQ_RESET;
         s_r.pclk_mhz    <= `RST_PCLK_MHZ;
         s_r.we_permit   <= `RST_WE_PERMIT;
         s_r.cmd_locked  <= `RST_CMD_LOCK;
         s_r.stat0       <= 8'h80;
         we_ok_r         <= 1'b1;
      end else begin
         s_r     <= s_nxt;
         we_ok_r <= we_ok_nxt;
      end
   end

   assign prdata                  = s_r.prdata;
   assign pready                  = s_r.pready;
   assign pslverr                 = s_r.pslverr;
   assign flash_access_error_irq  = s_r.irq;
   assign sequencer_ram_access_en = s_r.ram_en;
   assign lock_protection_cancel  = s_r.lock_cancel;
   assign sequencer_reset_bit     = s_r.seq_reset;
   assign code_flash_pe_entry     = s_r.cf_entry;
   assign data_flash_pe_entry     = s_r.df_entry;
   assign periph_clock_mhz        = s_r.pclk_mhz;
   assign write_erase_allowed     = we_ok_r;

endmodule
`default_nettype wire

// >>> verification/flash_pe_control_registers_sva.sv
// Concurrent checks on the ports of the flash program/erase control registers.
`timescale 1ns/10ps
`default_nettype none
`include "flash_pe_regs.svh"

module flash_pe_control_registers_sva (
   // Clock, reset and APB.
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   // Control outputs.
   input  wire logic        flash_access_error_irq,
   input  wire logic        sequencer_ram_access_en,
   input  wire logic        lock_protection_cancel,
   input  wire logic        sequencer_reset_bit,
   input  wire logic        code_flash_pe_entry,
   input  wire logic        data_flash_pe_entry,
   input  wire logic        write_erase_allowed
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic bw, kw, wr_ram, wr_rst, wr_ent, wr_lock, wr_we;
   assign bw = psel && penable && pready && pwrite;
   assign kw = bw && pstrb == `STRB_HALF;
   assign wr_ram = kw && paddr == {`IDX_SEQ_RAM_EN, 2'b00} && pwdata[15:8] == `KEY_RAM_EN;
   assign wr_rst = kw && paddr == {`IDX_SEQ_RESET, 2'b00} && pwdata[15:8] == `KEY_RESET;
   assign wr_ent = kw && paddr == {`IDX_PE_ENTRY, 2'b00} && pwdata[15:8] == `KEY_ENTRY;
   assign wr_lock = kw && paddr == {`IDX_LOCK_PROTECT, 2'b00} && pwdata[15:8] == `KEY_LOCK;
   assign wr_we = bw && pstrb[0] && paddr == {`IDX_WE_PROTECT, 2'b00};

   pready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   pready_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
   ram_hold_a: assert property (!wr_ram |=> $stable(sequencer_ram_access_en))
      else $error("RAM enable changed without keyed write");
   ram_update_a: assert property (wr_ram |=> sequencer_ram_access_en == $past(pwdata[0]))
      else $error("RAM enable not updated");
   reset_hold_a: assert property (!wr_rst |=> $stable(sequencer_reset_bit))
      else $error("reset bit changed without keyed write");
   entry_hold_a: assert property (!wr_ent |=> $stable({code_flash_pe_entry, data_flash_pe_entry}))
      else $error("entry bits changed without keyed write");
   entry_update_a: assert property (wr_ent |=> {code_flash_pe_entry, data_flash_pe_entry} ==
      {$past(pwdata[0]), $past(pwdata[7])}) else $error("entry bits not updated");
   lock_gate_a: assert property (wr_lock && !code_flash_pe_entry && !data_flash_pe_entry
      |=> $stable(lock_protection_cancel)) else $error("cancel bit written in read mode");
   permit_map_a: assert property (wr_we |=> write_erase_allowed == ($past(pwdata[1:0]) == 2'h1))
      else $error("write/erase permit decode wrong");
   key_hidden_a: assert property (pready && !pwrite && paddr == {`IDX_SEQ_RAM_EN, 2'b00}
      |-> prdata[31:1] == 31'h0) else $error("key byte read back");
   cover property (wr_ram);
   cover property (flash_access_error_irq);
   cover property (pslverr);
endmodule

bind flash_pe_control_registers flash_pe_control_registers_sva i_sva (
   .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .flash_access_error_irq(flash_access_error_irq),
   .sequencer_ram_access_en(sequencer_ram_access_en),
   .lock_protection_cancel(lock_protection_cancel), .sequencer_reset_bit(sequencer_reset_bit),
   .code_flash_pe_entry(code_flash_pe_entry), .data_flash_pe_entry(data_flash_pe_entry),
   .write_erase_allowed(write_erase_allowed));
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking testbench of the flash program/erase control registers.
`timescale 1ns/10ps
`default_nettype none
`include "flash_pe_regs.svh"

module testbench;
   logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
   logic [3:0]  pstrb = 0, ev = 0, busy = 0;
   logic        pready, pslverr, err, we_set = 1, rd_set = 1, locked = 0;
   logic        prg_e = 0, ers_e = 0, ilg_e = 0, proc_e = 0;
   logic        irq, ram_en, lock_cn, seq_rst, cf_ent, df_ent, we_ok;
   logic [7:0]  mhz;
   int          fail_count = 0, compares = 0;

   always #50 clk = ~clk;

   flash_pe_control_registers i_flash_pe_control_registers (
      .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dflash_pe_cmd(ev[0]), .dflash_read(ev[1]),
      .dflash_write_enable_setting(we_set), .dflash_read_enable_setting(rd_set),
      .dflash_illegal_access(ev[2]), .code_flash_illegal_access(ev[3]),
      .seq_command_locked(locked), .seq_program_error(prg_e), .seq_erase_error(ers_e),
      .seq_illegal_command(ilg_e), .seq_pe_busy(busy[0]), .seq_cancel_busy(busy[1]),
      .seq_lock_read_busy(busy[2]), .seq_blank_check_busy(busy[3]),
      .seq_processing_error(proc_e), .flash_access_error_irq(irq),
      .sequencer_ram_access_en(ram_en), .lock_protection_cancel(lock_cn),
      .sequencer_reset_bit(seq_rst), .code_flash_pe_entry(cf_ent),
      .data_flash_pe_entry(df_ent), .periph_clock_mhz(mhz), .write_erase_allowed(we_ok));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [29:0] idx, input logic [31:0] d,
                      input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1;
      // The answer is taken at the rising edge where pready is seen high.
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, pready, 1'b1);
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task automatic rdc(input logic [29:0] idx, input logic [31:0] exp);
      apb(0, idx, 32'h0000_0000, 4'hf);
      chk(rd, exp);
   endtask

   task automatic gap(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic pulse(input int i);
      @(posedge clk) ev <= 4'h1 << i;
      @(posedge clk) ev <= 4'h0;
   endtask

   task automatic t_reset;
      gap(1);
      chk({ram_en, lock_cn, seq_rst, cf_ent, df_ent, irq, we_ok, mhz}, 32'h0000_0100);
      rdc(`IDX_STATUS_0, 32'h0000_0080);
      apb(0, 30'h0000_0000, 32'h0000_0000, 4'hf);
      chk({31'h0000_0000, err}, 32'h0000_0001);
      chk(rd, 32'h0000_0000);
   endtask

   // Wrong key and byte-wide writes must bounce, the keyed half-word write must land.
   task automatic t_keys;
      logic [29:0] idx [3] = '{`IDX_SEQ_RAM_EN, `IDX_SEQ_RESET, `IDX_PE_ENTRY};
      logic [7:0]  key [3] = '{`KEY_RAM_EN, `KEY_RESET, `KEY_ENTRY};
      logic [3:0]  pre [3] = '{4'h0, 4'h1, 4'h3};
      logic [3:0]  post [3] = '{4'h1, 4'h3, 4'hf};
      for (int i = 0; i < 3; i++) begin
         apb(1, idx[i], {16'h0000, ~key[i], 8'h81}, 4'h3);
         apb(1, idx[i], {16'h0000, key[i], 8'h81}, 4'h1);
         gap(1);
         chk({df_ent, cf_ent, seq_rst, ram_en}, pre[i]);
         apb(1, idx[i], {16'h0000, key[i], 8'h81}, 4'h3);
         gap(1);
         chk({df_ent, cf_ent, seq_rst, ram_en}, post[i]);
         rdc(idx[i], (i == 2) ? 32'h0000_0081 : 32'h0000_0001);
      end
      apb(1, `IDX_SEQ_RESET, 32'h0000_cc00, 4'h3);
      gap(1);
      chk(seq_rst, 1'b0);
   endtask

   task automatic t_lock;
      apb(1, `IDX_PE_ENTRY, 32'h0000_aa00, 4'h3);
      apb(1, `IDX_LOCK_PROTECT, 32'h0000_5501, 4'h3);
      gap(1);
      chk(lock_cn, 1'b0);
      apb(1, `IDX_PE_ENTRY, 32'h0000_aa01, 4'h3);
      apb(1, `IDX_LOCK_PROTECT, 32'h0000_5501, 4'h3);
      gap(1);
      chk(lock_cn, 1'b1);
   endtask

   task automatic t_flags;
      pulse(0);
      rdc(`IDX_ACC_STATUS, 32'h0000_0000);
      @(posedge clk) {we_set, rd_set} <= 2'b00;
      for (int i = 0; i < 4; i++) pulse(i);
      gap(1);
      chk(irq, 1'b0);
      apb(1, `IDX_ACC_STATUS, 32'h0000_0000, 4'h1);
      apb(1, `IDX_ACC_IRQ_EN, 32'h0000_009b, 4'h1);
      gap(2);
      chk(irq, 1'b1);
      rdc(`IDX_ACC_STATUS, 32'h0000_008b);
      apb(1, `IDX_ACC_STATUS, 32'h0000_00ff, 4'h1);
      rdc(`IDX_ACC_STATUS, 32'h0000_008b);
      apb(1, `IDX_ACC_STATUS, 32'h0000_0000, 4'h1);
      rdc(`IDX_ACC_STATUS, 32'h0000_0000);
      gap(2);
      chk(irq, 1'b0);
      @(posedge clk) locked <= 1;
      gap(3);
      chk(irq, 1'b1);
      rdc(`IDX_ACC_STATUS, 32'h0000_0010);
      apb(1, `IDX_ACC_IRQ_EN, 32'h0000_0000, 4'h1);
      gap(2);
      chk(irq, 1'b0);
   endtask

   task automatic t_status;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) busy <= 4'h1 << i;
         rdc(`IDX_STATUS_0, 32'h0000_0000);
      end
      @(posedge clk) {busy, prg_e, ers_e, ilg_e, proc_e} <= 8'h0f;
      rdc(`IDX_STATUS_0, 32'h0000_00f0);
      rdc(`IDX_STATUS_1, 32'h0000_0080);
      @(posedge clk) {prg_e, ers_e, ilg_e, proc_e} <= 4'h0;
      rdc(`IDX_STATUS_0, 32'h0000_0080);
      rdc(`IDX_STATUS_1, 32'h0000_0000);
   endtask

   task automatic t_misc;
      apb(1, `IDX_PCLK_NOTIFY, 32'h0000_0030, 4'h3);
      gap(1);
      chk(mhz, 8'h30);
      apb(1, `IDX_WE_PROTECT, 32'h0000_0002, 4'h1);
      gap(1);
      chk(we_ok, 1'b0);
      apb(1, `IDX_WE_PROTECT, 32'h0000_0001, 4'h1);
      gap(1);
      chk(we_ok, 1'b1);
   endtask

   task automatic close_out;
      if (fail_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1;
      t_reset;
      t_keys;
      t_lock;
      t_flags;
      t_status;
      t_misc;
      close_out;
   end

   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      close_out;
   end
endmodule
`default_nettype wire
